/* File: design/ddcf_pkg.sv */
// Purpose: Shared constants and types of the channel filter configuration bank
// Assumes: 8-bit channel address, 20-bit microport data word
// Notes:   All configuration registers clear to zero at reset

package ddcf_pkg;

  // ****************************************
  // Bus widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 20;
  localparam int COEF_W = 20;

  // ****************************************
  // Channel addresses
  // ****************************************
  localparam logic [7:0] OFF_COEF_TOP    = 8'h7f;
  localparam logic [7:0] OFF_OSC_CTRL    = 8'h88;
  localparam logic [7:0] OFF_RCIC_DEC    = 8'h90;
  localparam logic [7:0] OFF_RCIC_INT    = 8'h91;
  localparam logic [7:0] OFF_RCIC_SCALE  = 8'h92;
  localparam logic [7:0] OFF_RSVD_A      = 8'h93;
  localparam logic [7:0] OFF_FCIC_DEC    = 8'h94;
  localparam logic [7:0] OFF_FCIC_SCALE  = 8'h95;
  localparam logic [7:0] OFF_RSVD_B      = 8'h96;
  localparam logic [7:0] OFF_CFL_DEC     = 8'ha0;
  localparam logic [7:0] OFF_CFL_PHASE   = 8'ha1;
  localparam logic [7:0] OFF_CFL_TAPS    = 8'ha2;
  localparam logic [7:0] OFF_CFL_OFFSET  = 8'ha3;
  localparam logic [7:0] OFF_CFL_CTRL    = 8'ha4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OSC_SYNC_LSB   = 7;
  localparam int OSC_PORT_BIT   = 6;
  localparam int OSC_CLR_BIT    = 3;
  localparam int OSC_ADITH_BIT  = 2;
  localparam int OSC_PDITH_BIT  = 1;
  localparam int OSC_BYP_BIT    = 0;
  localparam int SCALE_LOUD_LSB  = 0;
  localparam int SCALE_QUIET_LSB = 5;
  localparam int SCALE_W         = 5;
  localparam int CTL_BIST_BIT   = 10;
  localparam int CTL_SRC_BIT    = 9;
  localparam int CTL_BANK_BIT   = 8;
  localparam int CTL_CEXP_BIT   = 7;
  localparam int CTL_FORCE_BIT  = 6;
  localparam int CTL_FMT_HI_BIT = 5;
  localparam int CTL_FMT_LO_BIT = 4;
  localparam int CTL_OSCALE_LSB = 0;

  // ****************************************
  // Reset value
  // ****************************************
  localparam logic [DATA_W-1:0] RST_REG = 20'h00000;

  // Output formats of the coefficient filter
  typedef enum logic [1:0] {FMT_FIXED, FMT_FLOAT8, FMT_FLOAT12} ddcf_fmt_t;

endpackage

/* File: design/ddcf_filt_if.sv */
// Purpose: Carrier between the register bank and the coefficient pointer logic
// Assumes: Both ends on the same clock
// Notes:   regs end owns configuration, filt end owns working state

`timescale 1ns/10ps

interface ddcf_filt_if;
  logic [7:0]  phase_reg;
  logic [7:0]  offset_reg;
  logic        bank;
  logic        mem_wr;
  logic [6:0]  mem_waddr;
  logic [19:0] mem_wdata;
  logic        filter_start;
  logic        output_sample;
  logic [7:0]  phase_sel;
  logic [7:0]  pointer;
  logic        mem_we;
  logic [7:0]  mem_addr;
  logic [19:0] mem_data;

  modport regs (output phase_reg, offset_reg, bank, mem_wr, mem_waddr, mem_wdata,
                output filter_start, output_sample,
                input  phase_sel, pointer, mem_we, mem_addr, mem_data);
  modport filt (input  phase_reg, offset_reg, bank, mem_wr, mem_waddr, mem_wdata,
                input  filter_start, output_sample,
                output phase_sel, pointer, mem_we, mem_addr, mem_data);
endinterface

/* File: design/ddcf_coef_ptr.sv */
// Purpose: Working phase, working coefficient pointer and coefficient memory writes
// Assumes: Strobes are one-cycle pulses synchronous to clk_i
// Notes:   Working values only change on their own strobes

`timescale 1ns/10ps

module ddcf_coef_ptr
  import ddcf_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  // Configuration side
  ddcf_filt_if.filt bus
);

  // ****************************************
  // Working phase and pointer
  // ****************************************
  logic [7:0] phase_sel_r;
  logic [7:0] pointer_r;

  // Phase only reloads on filter start; channel sync leaves it alone
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_sel_r <= 8'h00;
    else if (ce_i && bus.filter_start)
      phase_sel_r <= bus.phase_reg;
  end

  // Shadow copied per output sample, so a filter in progress never sees a torn offset
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pointer_r <= 8'h00;
    else if (ce_i && bus.output_sample)
      pointer_r <= bus.offset_reg;
  end

  // ****************************************
  // Coefficient memory write port
  // ****************************************
  logic        mem_we_r;
  logic [7:0]  mem_addr_r;
  logic [19:0] mem_data_r;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mem_we_r   <= 1'b0;
      mem_addr_r <= 8'h00;
      mem_data_r <= 20'h00000;
    end
    else if (ce_i)
    begin
      mem_we_r <= bus.mem_wr;
      if (bus.mem_wr)
      begin
        mem_addr_r <= {bus.bank, bus.mem_waddr};
        mem_data_r <= bus.mem_wdata;
      end
    end
  end

  assign bus.phase_sel = phase_sel_r;
  assign bus.pointer   = pointer_r;
  assign bus.mem_we    = mem_we_r;
  assign bus.mem_addr  = mem_addr_r;
  assign bus.mem_data  = mem_data_r;

  // ****************************************
  // Checks
  // ****************************************
  phase_reload_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && bus.filter_start) |=> (phase_sel_r == $past(bus.phase_reg)))
    else $error("working phase not reloaded on filter start");

  ptr_shadow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(ce_i && bus.output_sample) |=> $stable(pointer_r))
    else $error("working pointer moved without an output sample");

  coef_bank_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && bus.mem_wr) |=> (mem_we_r && mem_addr_r[7] == $past(bus.bank)))
    else $error("coefficient write lost its bank bit");

endmodule

/* File: design/ddcf_channel_cfg.sv */
// Purpose: Configuration register bank of one downconverter channel
// Assumes: Microport strobes and pins synchronous to clk_i; ce_i freezes all state
// Notes:   Reads answer one cycle after rd_i; unmapped and reserved read zero
// What this block does
// - Oscillator control bits 8-7 pick sync pin A, B, C or D.
// - Oscillator control bit 6 picks input port A (0) or B (1).
// - Bit 3 set clears the phase accumulator on every hop.
// - Bits 2 and 1 enable amplitude and phase dither.
// - Bit 0 bypasses translation: port A to I path, port B to Q.
// - Resampling decimation register holds decimation minus one, must exceed interpolation.
// - Resampling interpolation register holds interpolation minus one, 1 to 512.
// - Resampling scale: bits 9-5 while level indicator active, 4-0 otherwise.
// - Fifth-order decimation minus one, 8 bits, plus a 5-bit scale.
// - Coefficient filter decimation minus one, 8 bits, up to 256.
// - Phase register reloads on filter start, kept across synchronization.
// - Tap count register holds taps minus one.
// - Coefficient offset shadow copied to working pointer each output sample.
// - Control bit 10 bypasses filter to the self-test signature registers.
// - Control bit 9 takes another channel's output: 0<-1, 1<-0, 2<-1, 3<-1.
// - Control bit 8 is the upper coefficient memory address bit.
// - Bit 7 chooses shared or separate exponents in floating modes.
// - Bit 6 forces the output scale in floating modes, saturating mantissas.
// - Bits 5-4 pick format: 1x 12+4, 01 8+4, 00 fixed.

`timescale 1ns/10ps

module ddcf_channel_cfg
  import ddcf_pkg::*;
#(
  parameter int CHANNEL_ID = 0
)
(
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  // Microport
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   rvalid_o,
  // Sync and hop
  input  wire logic [3:0]        sync_pins_i,
  input  wire logic              soft_hop_i,
  output logic                   sync_o,
  output logic                   phase_clear_o,
  // Converter inputs and channel paths
  input  wire logic [11:0]       port_a_i,
  input  wire logic [11:0]       port_b_i,
  output logic      [11:0]       chan_i_o,
  output logic      [11:0]       chan_q_o,
  output logic                   amp_dither_o,
  output logic                   phase_dither_o,
  // Resampling and fifth-order stages
  input  wire logic              level_indicator_i,
  output logic      [12:0]       resample_decimation_o,
  output logic      [9:0]        resample_interpolation_o,
  output logic                   resample_cfg_ok_o,
  output logic      [4:0]        resample_scale_o,
  output logic      [7:0]        fifth_cic_decim_m1_o,
  output logic      [4:0]        fifth_cic_scale_o,
  // Coefficient filter
  input  wire logic              filter_start_i,
  input  wire logic              output_sample_i,
  output logic      [8:0]        coef_filter_decimation_o,
  output logic      [8:0]        coef_filter_tap_count_o,
  output logic      [7:0]        coef_filter_phase_sel_o,
  output logic      [7:0]        coef_filter_pointer_o,
  output logic                   bist_bypass_o,
  output logic                   use_other_o,
  output logic      [1:0]        src_channel_o,
  output logic                   common_exp_o,
  output logic                   force_scale_o,
  output ddcf_fmt_t              out_fmt_o,
  output logic      [3:0]        out_scale_o,
  // Coefficient memory write port
  output logic                   coef_mem_we_o,
  output logic      [7:0]        coef_mem_addr_o,
  output logic      [COEF_W-1:0] coef_mem_data_o
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [8:0]  osc_r;
  logic [11:0] rcic_dec_r;
  logic [8:0]  rcic_int_r;
  logic [9:0]  rcic_scale_r;
  logic [7:0]  fcic_dec_r;
  logic [4:0]  fcic_scale_r;
  logic [7:0]  cfl_dec_r;
  logic [7:0]  cfl_phase_r;
  logic [7:0]  cfl_taps_r;
  logic [7:0]  cfl_offset_r;
  logic [10:0] cfl_ctrl_r;
  logic        wr_en;

  assign wr_en = ce_i && wr_i;

  // Reserved bits are never stored, so they read zero whatever was written
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      osc_r <= RST_REG[8:0];
    else if (wr_en && addr_i == OFF_OSC_CTRL)
      osc_r <= {wdata_i[8:6], 2'b00, wdata_i[3:0]};
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rcic_dec_r   <= RST_REG[11:0];
      rcic_int_r   <= RST_REG[8:0];
      rcic_scale_r <= RST_REG[9:0];
    end
    else if (wr_en)
    begin
      if (addr_i == OFF_RCIC_DEC)
        rcic_dec_r <= wdata_i[11:0];
      if (addr_i == OFF_RCIC_INT)
        rcic_int_r <= wdata_i[8:0];
      if (addr_i == OFF_RCIC_SCALE)
        rcic_scale_r <= wdata_i[9:0];
    end
  end

  // Writes to 0x93 and 0x96 are dropped; those registers hold nothing
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fcic_dec_r   <= RST_REG[7:0];
      fcic_scale_r <= RST_REG[4:0];
    end
    else if (wr_en)
    begin
      if (addr_i == OFF_FCIC_DEC)
        fcic_dec_r <= wdata_i[7:0];
      if (addr_i == OFF_FCIC_SCALE)
        fcic_scale_r <= wdata_i[4:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfl_dec_r    <= RST_REG[7:0];
      cfl_phase_r  <= RST_REG[7:0];
      cfl_taps_r   <= RST_REG[7:0];
      cfl_offset_r <= RST_REG[7:0];
      cfl_ctrl_r   <= RST_REG[10:0];
    end
    else if (wr_en)
    begin
      if (addr_i == OFF_CFL_DEC)
        cfl_dec_r <= wdata_i[7:0];
      if (addr_i == OFF_CFL_PHASE)
        cfl_phase_r <= wdata_i[7:0];
      if (addr_i == OFF_CFL_TAPS)
        cfl_taps_r <= wdata_i[7:0];
      if (addr_i == OFF_CFL_OFFSET)
        cfl_offset_r <= wdata_i[7:0];
      if (addr_i == OFF_CFL_CTRL)
        cfl_ctrl_r <= wdata_i[10:0];
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = RST_REG;
    case (addr_i)
      OFF_OSC_CTRL:   rd_mux[8:0]  = osc_r;
      OFF_RCIC_DEC:   rd_mux[11:0] = rcic_dec_r;
      OFF_RCIC_INT:   rd_mux[8:0]  = rcic_int_r;
      OFF_RCIC_SCALE: rd_mux[9:0]  = rcic_scale_r;
      OFF_FCIC_DEC:   rd_mux[7:0]  = fcic_dec_r;
      OFF_FCIC_SCALE: rd_mux[4:0]  = fcic_scale_r;
      OFF_CFL_DEC:    rd_mux[7:0]  = cfl_dec_r;
      OFF_CFL_PHASE:  rd_mux[7:0]  = cfl_phase_r;
      OFF_CFL_TAPS:   rd_mux[7:0]  = cfl_taps_r;
      OFF_CFL_OFFSET: rd_mux[7:0]  = cfl_offset_r;
      OFF_CFL_CTRL:   rd_mux[10:0] = cfl_ctrl_r;
      default:        rd_mux       = RST_REG;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o  <= RST_REG;
      rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rvalid_o <= rd_i;
      if (rd_i)
        rdata_o <= rd_mux;
    end
  end

  // ****************************************
  // Sync select and hop
  // ****************************************
  logic sync_now;
  logic hop_ev;

  assign sync_now = sync_pins_i[osc_r[OSC_SYNC_LSB +: 2]];
  assign hop_ev   = soft_hop_i || (sync_now && !sync_o);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync_o        <= 1'b0;
      phase_clear_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sync_o        <= sync_now;
      phase_clear_o <= hop_ev && osc_r[OSC_CLR_BIT];
    end
  end

  // ****************************************
  // Input port and bypass paths
  // ****************************************
  logic [11:0] port_sel;

  assign port_sel = osc_r[OSC_PORT_BIT] ? port_b_i : port_a_i;

  // Without bypass the channel is real: Q is zero until the mixer
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      chan_i_o       <= 12'h000;
      chan_q_o       <= 12'h000;
      amp_dither_o   <= 1'b0;
      phase_dither_o <= 1'b0;
    end
    else if (ce_i)
    begin
      chan_i_o       <= osc_r[OSC_BYP_BIT] ? port_a_i : port_sel;
      chan_q_o       <= osc_r[OSC_BYP_BIT] ? port_b_i : 12'h000;
      amp_dither_o   <= osc_r[OSC_ADITH_BIT];
      phase_dither_o <= osc_r[OSC_PDITH_BIT];
    end
  end

  // ****************************************
  // Resampling and fifth-order stage values
  // ****************************************
  logic [4:0] scale_pick;

  assign scale_pick = level_indicator_i ? rcic_scale_r[SCALE_QUIET_LSB +: SCALE_W]
                                        : rcic_scale_r[SCALE_LOUD_LSB +: SCALE_W];

  // Ratio flag lets software spot an illegal decimation/interpolation pair
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      resample_decimation_o    <= 13'h0001;
      resample_interpolation_o <= 10'h001;
      resample_cfg_ok_o        <= 1'b0;
      resample_scale_o         <= 5'h00;
      fifth_cic_decim_m1_o     <= 8'h00;
      fifth_cic_scale_o        <= 5'h00;
    end
    else if (ce_i)
    begin
      resample_decimation_o    <= 13'(rcic_dec_r) + 13'h0001;
      resample_interpolation_o <= 10'(rcic_int_r) + 10'h001;
      resample_cfg_ok_o        <= rcic_dec_r > 12'(rcic_int_r);
      resample_scale_o         <= scale_pick;
      fifth_cic_decim_m1_o     <= fcic_dec_r;
      fifth_cic_scale_o        <= fcic_scale_r;
    end
  end

  // ****************************************
  // Coefficient filter control
  // ****************************************
  logic [1:0] src_map;
  ddcf_fmt_t  fmt_dec;

  always_comb
  begin
    case (CHANNEL_ID)
      0:       src_map = 2'h1;
      1:       src_map = 2'h0;
      default: src_map = 2'h1;
    endcase
  end

  always_comb
  begin
    if (cfl_ctrl_r[CTL_FMT_HI_BIT])
      fmt_dec = FMT_FLOAT12;
    else if (cfl_ctrl_r[CTL_FMT_LO_BIT])
      fmt_dec = FMT_FLOAT8;
    else
      fmt_dec = FMT_FIXED;
  end

  // Exponent choice only matters in floating modes, so it is masked in fixed point
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      coef_filter_decimation_o <= 9'h001;
      coef_filter_tap_count_o  <= 9'h001;
      bist_bypass_o            <= 1'b0;
      use_other_o              <= 1'b0;
      src_channel_o            <= 2'h0;
      common_exp_o             <= 1'b0;
      force_scale_o            <= 1'b0;
      out_fmt_o                <= FMT_FIXED;
      out_scale_o              <= 4'h0;
    end
    else if (ce_i)
    begin
      coef_filter_decimation_o <= 9'(cfl_dec_r) + 9'h001;
      coef_filter_tap_count_o  <= 9'(cfl_taps_r) + 9'h001;
      bist_bypass_o            <= cfl_ctrl_r[CTL_BIST_BIT];
      use_other_o              <= cfl_ctrl_r[CTL_SRC_BIT];
      src_channel_o            <= cfl_ctrl_r[CTL_SRC_BIT] ? src_map : 2'(CHANNEL_ID);
      common_exp_o             <= cfl_ctrl_r[CTL_CEXP_BIT] && fmt_dec != FMT_FIXED;
      force_scale_o            <= cfl_ctrl_r[CTL_FORCE_BIT];
      out_fmt_o                <= fmt_dec;
      out_scale_o              <= cfl_ctrl_r[CTL_OSCALE_LSB +: 4];
    end
  end

  // ****************************************
  // Working pointer and coefficient writes
  // ****************************************
  ddcf_filt_if filt_bus ();

  assign filt_bus.phase_reg     = cfl_phase_r;
  assign filt_bus.offset_reg    = cfl_offset_r;
  assign filt_bus.bank          = cfl_ctrl_r[CTL_BANK_BIT];
  assign filt_bus.mem_wr        = wr_i && addr_i <= OFF_COEF_TOP;
  assign filt_bus.mem_waddr     = addr_i[6:0];
  assign filt_bus.mem_wdata     = wdata_i;
  assign filt_bus.filter_start  = filter_start_i;
  assign filt_bus.output_sample = output_sample_i;

  ddcf_coef_ptr u_coef_ptr
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .bus       (filt_bus)
  );

  assign coef_filter_phase_sel_o = filt_bus.phase_sel;
  assign coef_filter_pointer_o   = filt_bus.pointer;
  assign coef_mem_we_o           = filt_bus.mem_we;
  assign coef_mem_addr_o         = filt_bus.mem_addr;
  assign coef_mem_data_o         = filt_bus.mem_data;

  // ****************************************
  // Checks
  // ****************************************
  sync_select_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i |=> (sync_o == $past(sync_now)))
    else $error("sync output not following the selected pin");

  port_select_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && !osc_r[OSC_BYP_BIT]) |=> (chan_i_o == $past(port_sel) && chan_q_o == 12'h000))
    else $error("I path not fed from the selected port");

  bypass_path_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && osc_r[OSC_BYP_BIT]) |=> (chan_i_o == $past(port_a_i) && chan_q_o == $past(port_b_i)))
    else $error("bypass does not route A to I and B to Q");

  hop_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && soft_hop_i) |=> (phase_clear_o == $past(osc_r[OSC_CLR_BIT])))
    else $error("phase clear does not follow the hop and clear bit");

  osc_reserved_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && rd_i && addr_i == OFF_OSC_CTRL) |=> (rvalid_o && rdata_o[5:4] == 2'b00))
    else $error("reserved oscillator bits read nonzero");

  scale_pick_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && level_indicator_i) |=> (resample_scale_o == $past(rcic_scale_r[9:5])))
    else $error("active level indicator did not select the upper scale");

  decim_offset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i |=> (resample_decimation_o == 13'($past(rcic_dec_r)) + 13'h0001))
    else $error("resampling decimation not register plus one");

  fmt_decode_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && cfl_ctrl_r[5:4] == 2'b01) |=> (out_fmt_o == FMT_FLOAT8))
    else $error("format 01 did not decode to 8+4");

endmodule

/* File: sim/ddc_channel_filter_config_tb_top.sv */
// Purpose: Self-checking bench of the channel configuration bank
// Assumes: Channel 0; ce_i held high except for one frozen write in t_cic
// Notes:   Derived outputs are sampled two edges after the write
`timescale 1ns/10ps
module ddc_channel_filter_config_tb_top
  import ddcf_pkg::*;
;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        soft_hop_i = 1'b0, level_indicator_i = 1'b0;
  logic        filter_start_i = 1'b0, output_sample_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [19:0] wdata_i = 20'h00000;
  logic [3:0]  sync_pins_i = 4'h0;
  logic [11:0] port_a_i = 12'h123, port_b_i = 12'h456;
  logic [19:0] rdata_o, coef_mem_data_o;
  logic        rvalid_o, sync_o, phase_clear_o, amp_dither_o, phase_dither_o;
  logic        resample_cfg_ok_o, bist_bypass_o, use_other_o, common_exp_o;
  logic        force_scale_o, coef_mem_we_o;
  logic [11:0] chan_i_o, chan_q_o;
  logic [12:0] resample_decimation_o;
  logic [9:0]  resample_interpolation_o;
  logic [4:0]  resample_scale_o, fifth_cic_scale_o;
  logic [7:0]  fifth_cic_decim_m1_o, coef_filter_phase_sel_o, coef_filter_pointer_o;
  logic [7:0]  coef_mem_addr_o;
  logic [8:0]  coef_filter_decimation_o, coef_filter_tap_count_o;
  logic [1:0]  src_channel_o;
  logic [3:0]  out_scale_o;
  ddcf_fmt_t   out_fmt_o;
  int          err_count = 0, comparisons = 0, cycles = 0;

  ddcf_channel_cfg dut_u (.clk_i, .reset_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .rvalid_o, .sync_pins_i, .soft_hop_i, .sync_o, .phase_clear_o, .port_a_i,
    .port_b_i, .chan_i_o, .chan_q_o, .amp_dither_o, .phase_dither_o, .level_indicator_i,
    .resample_decimation_o, .resample_interpolation_o, .resample_cfg_ok_o,
    .resample_scale_o, .fifth_cic_decim_m1_o, .fifth_cic_scale_o, .filter_start_i,
    .output_sample_i, .coef_filter_decimation_o, .coef_filter_tap_count_o,
    .coef_filter_phase_sel_o, .coef_filter_pointer_o, .bist_bypass_o, .use_other_o,
    .src_channel_o, .common_exp_o, .force_scale_o, .out_fmt_o, .out_scale_o,
    .coef_mem_we_o, .coef_mem_addr_o, .coef_mem_data_o);

  always #5 clk_i = ~clk_i;

  // ****************************************
  // Bus cycles and comparison
  // ****************************************
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [19:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk("rvalid", {19'h0, rvalid_o}, 20'h1);
    chk("rdata", rdata_o, exp);
  endtask

  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask

  // One-cycle strobe: 0 hop, 1 filter start, 2 output sample
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: soft_hop_i <= 1'b1;
      1: filter_start_i <= 1'b1;
      default: output_sample_i <= 1'b1;
    endcase
    @(posedge clk_i);
    soft_hop_i      <= 1'b0;
    filter_start_i  <= 1'b0;
    output_sample_i <= 1'b0;
    #1;
  endtask

  task automatic test_done;
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_osc;
    for (int s = 0; s < 4; s++)
    begin
      wr(OFF_OSC_CTRL, 20'(s << 7));
      @(posedge clk_i) sync_pins_i <= ~(4'h1 << s);
      settle();
      chk("sync_off", {19'h0, sync_o}, 20'h0);
      @(posedge clk_i) sync_pins_i <= 4'h1 << s;
      settle();
      chk("sync_on", {19'h0, sync_o}, 20'h1);
      @(posedge clk_i) sync_pins_i <= 4'h0;
    end
    wr(OFF_OSC_CTRL, 20'h00046);
    settle();
    chk("i_path", chan_i_o, 12'h456);
    chk("dither", {amp_dither_o, phase_dither_o}, 2'b11);
    wr(OFF_OSC_CTRL, 20'h00001);
    settle();
    chk("byp_i", chan_i_o, 12'h123);
    chk("byp_q", chan_q_o, 12'h456);
    wr(OFF_OSC_CTRL, 20'h001cf);
    rdchk(OFF_OSC_CTRL, 20'h001cf);
    pulse(0);
    chk("clear_on", {19'h0, phase_clear_o}, 20'h1);
    @(posedge clk_i) sync_pins_i <= 4'h8;
    settle();
    chk("pin_clear", {19'h0, phase_clear_o}, 20'h1);
    @(posedge clk_i) sync_pins_i <= 4'h0;
    wr(OFF_OSC_CTRL, 20'h00000);
    pulse(0);
    chk("clear_off", {19'h0, phase_clear_o}, 20'h0);
  endtask

  task automatic t_cic;
    logic [7:0] rsv [5] = '{8'h93, 8'h96, 8'h89, 8'h9f, 8'ha5};
    wr(OFF_RCIC_DEC, 20'h00fff);
    wr(OFF_RCIC_INT, 20'h001ff);
    settle();
    chk("rdec", resample_decimation_o, 13'd4096);
    chk("rint", resample_interpolation_o, 10'd512);
    chk("ok_hi", {19'h0, resample_cfg_ok_o}, 20'h1);
    wr(OFF_RCIC_DEC, 20'h001ff);
    settle();
    chk("ok_eq", {19'h0, resample_cfg_ok_o}, 20'h0);
    wr(OFF_RCIC_SCALE, 20'h002a5);
    rdchk(OFF_RCIC_SCALE, 20'h002a5);
    @(posedge clk_i) level_indicator_i <= 1'b1;
    settle();
    chk("scale_li", resample_scale_o, 5'h15);
    @(posedge clk_i) level_indicator_i <= 1'b0;
    settle();
    chk("scale_q", resample_scale_o, 5'h05);
    wr(OFF_FCIC_DEC, 20'h000ab);
    wr(OFF_FCIC_SCALE, 20'h0001f);
    settle();
    chk("c5", {fifth_cic_decim_m1_o, fifth_cic_scale_o}, 13'h157f);
    // Write while frozen must be lost
    @(posedge clk_i) ce_i <= 1'b0;
    wr(OFF_FCIC_SCALE, 20'h00000);
    @(posedge clk_i) ce_i <= 1'b1;
    settle();
    chk("ce_hold", fifth_cic_scale_o, 5'h1f);
    foreach (rsv[i])
    begin
      wr(rsv[i], i < 2 ? 20'h00000 : 20'hfffff);
      rdchk(rsv[i], 20'h00000);
    end
  endtask

  task automatic t_rcf;
    wr(OFF_CFL_DEC, 20'h000ff);
    wr(OFF_CFL_TAPS, 20'h0001f);
    wr(OFF_CFL_PHASE, 20'h0005a);
    wr(OFF_CFL_OFFSET, 20'h0003c);
    settle();
    chk("rcf_dec", coef_filter_decimation_o, 9'd256);
    chk("taps", coef_filter_tap_count_o, 9'd32);
    chk("ph_hold", coef_filter_phase_sel_o, 8'h00);
    chk("ptr_hold", coef_filter_pointer_o, 8'h00);
    pulse(1);
    chk("ph_load", coef_filter_phase_sel_o, 8'h5a);
    pulse(2);
    chk("ptr_load", coef_filter_pointer_o, 8'h3c);
    for (int f = 0; f < 4; f++)
    begin
      wr(OFF_CFL_CTRL, 20'h007c5 | 20'(f << 4));
      settle();
      chk("fmt", out_fmt_o, f[1] ? FMT_FLOAT12 : (f[0] ? FMT_FLOAT8 : FMT_FIXED));
      chk("cexp", {19'h0, common_exp_o}, 20'(f != 0));
      chk("force", {force_scale_o, out_scale_o}, 5'h15);
      chk("bist", {19'h0, bist_bypass_o}, 20'h1);
      chk("other", {use_other_o, src_channel_o}, 3'b101);
    end
    wr(OFF_CFL_CTRL, 20'h00100);
    settle();
    chk("own", {use_other_o, src_channel_o}, 3'b000);
    wr(8'h05, 20'h12345);
    chk("cm_we_hi", {19'h0, coef_mem_we_o}, 20'h1);
    chk("cm_hi", coef_mem_addr_o, 8'h85);
    chk("cm_d_hi", coef_mem_data_o, 20'h12345);
    wr(OFF_CFL_CTRL, 20'h00000);
    wr(OFF_COEF_TOP, 20'habcde);
    chk("cm_we_lo", {19'h0, coef_mem_we_o}, 20'h1);
    chk("cm_lo", coef_mem_addr_o, 8'h7f);
    chk("cm_d_lo", coef_mem_data_o, 20'habcde);
  endtask

  // Long enough for all scenarios several times over
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      test_done();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    settle();
    chk("rst_rdec", resample_decimation_o, 13'd1);
    chk("rst_taps", coef_filter_tap_count_o, 9'd1);
    chk("rst_fmt", out_fmt_o, FMT_FIXED);
    t_osc();
    t_cic();
    t_rcf();
    test_done();
  end
endmodule
